// *** ipt_pinmux.sv ***
`timescale 1ns/10ps
`default_nettype none
// Maps a reference event onto one pin, with polarity
module ipt_pinmux import ipt_pkg::*; (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic [5:0] i_events,
	input wire logic [2:0] i_sel,
	input wire logic i_invert,
	output logic o_pin
);
	// Registered pin, active-high unless inverted
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_pin <= 1'b0;
		end else begin
			o_pin <= ((i_sel < 3'h6) ? i_events[i_sel] : 1'b0) ^ i_invert;
		end
	end
endmodule
`default_nettype wire

// *** ipt_pkg.sv ***
package ipt_pkg;
	// Register map of the plain register port (word index = address)
	localparam logic [3:0] IPT_REG_CTRL = 4'h0;
	localparam logic [3:0] IPT_REG_DID = 4'h1;
	localparam logic [3:0] IPT_REG_SDID = 4'h2;
	localparam logic [3:0] IPT_REG_PINMAP = 4'h3;
	localparam logic [3:0] IPT_REG_POL = 4'h4;
	localparam logic [3:0] IPT_REG_STATUS = 4'h5;
	// Control register field positions
	localparam int IPT_CTRL_REMAP_BIT = 0;
	localparam int IPT_CTRL_NOCODES_BIT = 1;
	localparam int IPT_CTRL_PULSE_BIT = 2;
	localparam int IPT_CTRL_PAGEA_BIT = 3;
	localparam int IPT_CTRL_PAGEB_BIT = 4;
	// Reset values
	localparam logic [7:0] IPT_CTRL_RST = 8'h00;
	localparam logic [5:0] IPT_DID_RST = 6'h3E;
	localparam logic [5:0] IPT_SDID_RST = 6'h00;
	localparam logic [14:0] IPT_PINMAP_RST = 15'h0000;
	localparam logic [4:0] IPT_POL_RST = 5'h00;
	// Framing constants
	localparam logic [7:0] IPT_INVALID = 8'h00;
	localparam logic [7:0] IPT_PRE_FF = 8'hFF;
	localparam logic [7:0] IPT_FILL = 8'hA0;
	localparam logic [7:0] IPT_REMAP_LO = 8'h03;
	localparam logic [7:0] IPT_REMAP_HI = 8'hFC;
	localparam logic [5:0] IPT_DID_SAV_HI = 6'h3E;
	localparam logic [5:0] IPT_DID_SAV_LO = 6'h3F;
	localparam logic [5:0] IPT_DC_FIXED = 6'h0B;
	localparam int IPT_DC_BYTES = 44;
	localparam int IPT_TXT_DEPTH = 64;
	// Reference events selectable on each pin
	localparam logic [2:0] IPT_EV_QUAL = 3'h0;
	localparam logic [2:0] IPT_EV_HORIZONTAL_GATE = 3'h1;
	localparam logic [2:0] IPT_EV_VREF = 3'h2;
	localparam logic [2:0] IPT_EV_FIELD = 3'h3;
	localparam logic [2:0] IPT_EV_SLICED = 3'h4;
	localparam logic [2:0] IPT_EV_LOW = 3'h5;
	// Video stream beat from the scaler
	typedef struct packed {
		logic [7:0] data;
		logic sol;
		logic eol;
		logic vblank;
		logic last_active;
		logic field;
		logic task_b;
	} ipt_vid_t;
	// Sliced line byte from the slicer
	typedef struct packed {
		logic [7:0] data;
		logic last;
	} ipt_txt_t;
	// Line header for a sliced line
	typedef struct packed {
		logic [8:0] line_num;
		logic [3:0] std;
		logic field;
	} ipt_hdr_t;
endpackage

// *** ipt_port.sv ***
// Behaviour
// - Text store has two line sections
// - Text sent only after whole line, gapless
// - Each sliced line led by line-number/standard header
// - Identifier below 3E gives ANC, else SAV/EAV
// - Sliced flag set at ANC start, cleared at SAV
// - Remap 00/FF to 03/FC when enabled
// - Text inserted after video line, when video idle
// - Gates active while references are high
// - Optional pulses on gate rising edges
// - Qualifier marks data, invalid cycles carry 00
// - Timing codes can be suppressed
// - Hold input stalls output; bursts follow
// - Events mappable to pins, polarity programmable
// - SAV codes for active line start
// - EAV codes after non-final active line
// - SAV codes for blanking line start
// - EAV codes after final active or blanking line
// - Each SAV/EAV code preceded by FF 00 00, ANC identifier by 00 FF FF
// - Video code MSB is inverted page select
// - Text code MSB 1 for 3E, 0 for 3F
// - Dword count fixed 0B for SAV/EAV, from line length for ANC; fill A0
// - Checksum from SAV/identifier to last data
`timescale 1ns/10ps
`default_nettype none
module ipt_port import ipt_pkg::*; #(
	parameter int DEPTH = IPT_TXT_DEPTH
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_vid_valid,
	input wire ipt_vid_t i_vid,
	output logic o_vid_ready,
	input wire logic i_txt_valid,
	input wire ipt_txt_t i_txt,
	input wire ipt_hdr_t i_txt_hdr,
	output logic o_txt_ready,
	input wire logic i_output_hold_gate_in,
	output logic [7:0] o_data,
	output logic o_output_qualifier_pin,
	output logic o_horizontal_ref_pin,
	output logic o_vertical_ref_pin,
	output logic o_general_purpose_out_a,
	output logic o_general_purpose_out_b
);
	localparam int AW = $clog2(DEPTH);
	// Output sequencer states
	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_PRE = 7'b0000010,
		ST_CODE = 7'b0000100,
		ST_VID = 7'b0001000,
		ST_HDR = 7'b0010000,
		ST_TXT = 7'b0100000,
		ST_TAIL = 7'b1000000
	} ipt_st_t;
	// Entire block state
	typedef struct packed {
		ipt_st_t st;
		logic [1:0] pre;
		logic code_eav;
		logic code_txt;
		logic [7:0] code;
		logic [2:0] hdr_i;
		logic [5:0] cnt;
		logic [5:0] nvalid;
		logic [7:0] cs;
		logic tail_i;
		logic [7:0] data;
		logic qual;
		logic horizontal_gate;
		logic vref;
		logic horizontal_gate_p;
		logic vref_p;
		logic field;
		logic sliced;
		logic [1:0] full;
		logic wsec;
		logic rsec;
		logic [AW-1:0] wptr;
		logic [5:0] len0;
		logic [5:0] len1;
		ipt_hdr_t hdr0;
		ipt_hdr_t hdr1;
		logic [7:0] ctrl;
		logic [5:0] text_header_identifier;
		logic [5:0] sdid;
		logic [14:0] pinmap;
		logic [4:0] pol;
		logic [31:0] rdata;
	} ipt_state_t;
	ipt_state_t s_q, s_d;
	logic [7:0] mem_rdata; // Registered text byte
	logic [AW-1:0] mem_raddr; // Text read address
	logic [5:0] events; // Reference events for pin mapping
	// Even parity of six bits placed with inverted copy above
	function automatic logic [7:0] ipt_par6(input logic [5:0] v);
		ipt_par6 = {~(^v), ^v, v};
	endfunction
	// Odd parity over seven bits in the top position
	function automatic logic [7:0] ipt_par7(input logic [6:0] v);
		ipt_par7 = {~(^v), v};
	endfunction
	// Timing code with MSB, field, V and H bits and protection bits
	function automatic logic [7:0] ipt_code(input logic m, input logic f,
			input logic v, input logic h);
		ipt_code = {m, f, v, h, ~(m ^ v ^ h), ~(m ^ f ^ h), ~(m ^ f ^ v), f ^ v ^ h};
	endfunction
	wire ipt_hdr_t cur_hdr = s_q.rsec ? s_q.hdr1 : s_q.hdr0; // Line in transfer
	wire logic [5:0] cur_len = s_q.rsec ? s_q.len1 : s_q.len0; // Its byte count
	wire logic sav_mode = (s_q.text_header_identifier >= IPT_DID_SAV_HI);
	wire logic no_codes = s_q.ctrl[IPT_CTRL_NOCODES_BIT];
	wire logic hold = i_output_hold_gate_in; // Stall from outside
	wire logic [5:0] anc_dc = 6'((6'd2 + cur_len + 6'd3) >> 2); // ANC Dword count
	// Text byte with optional remap
	function automatic logic [7:0] ipt_remap(input logic [7:0] b, input logic en);
		if (en && b == 8'h00) begin
			ipt_remap = IPT_REMAP_LO;
		end else if (en && b == 8'hFF) begin
			ipt_remap = IPT_REMAP_HI;
		end else begin
			ipt_remap = b;
		end
	endfunction
	assign mem_raddr = AW'(s_d.cnt); // Next index, so the registered byte lines up with cnt
	ipt_txt_mem #(.DEPTH(DEPTH)) u_mem (
		.i_clk_sys(i_clk_sys),
		.i_we(i_txt_valid && o_txt_ready),
		.i_wsec(s_q.wsec),
		.i_waddr(s_q.wptr),
		.i_wdata(i_txt.data),
		.i_rsec(s_q.rsec),
		.i_raddr(mem_raddr),
		.o_rdata(mem_rdata)
	);
	// Gates, or pulses on their rising edges
	assign events = {1'b0, s_q.sliced, s_q.field,
		s_q.ctrl[IPT_CTRL_PULSE_BIT] ? s_q.vref & ~s_q.vref_p : s_q.vref,
		s_q.ctrl[IPT_CTRL_PULSE_BIT] ? s_q.horizontal_gate & ~s_q.horizontal_gate_p : s_q.horizontal_gate,
		s_q.qual};
	// One mapper per pin
	ipt_pinmux u_pq (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_events(events),
		.i_sel(s_q.pinmap[2:0]), .i_invert(s_q.pol[0]), .o_pin(o_output_qualifier_pin));
	ipt_pinmux u_ph (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_events(events),
		.i_sel(s_q.pinmap[5:3] ^ IPT_EV_HORIZONTAL_GATE), .i_invert(s_q.pol[1]),
		.o_pin(o_horizontal_ref_pin));
	ipt_pinmux u_pv (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_events(events),
		.i_sel(s_q.pinmap[8:6] ^ IPT_EV_VREF), .i_invert(s_q.pol[2]),
		.o_pin(o_vertical_ref_pin));
	ipt_pinmux u_pa (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_events(events),
		.i_sel(s_q.pinmap[11:9] ^ IPT_EV_SLICED), .i_invert(s_q.pol[3]),
		.o_pin(o_general_purpose_out_a));
	ipt_pinmux u_pb (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_events(events),
		.i_sel(s_q.pinmap[14:12] ^ IPT_EV_FIELD), .i_invert(s_q.pol[4]),
		.o_pin(o_general_purpose_out_b));
	// Video accepted only while streaming pixels and not held
	assign o_vid_ready = (s_q.st == ST_VID) && !hold;
	// Slicer may write while the write section is free
	assign o_txt_ready = !s_q.full[s_q.wsec];
	assign o_data = s_q.data;
	assign o_rdata = s_q.rdata;
	// Next-state logic
	always_comb begin
		s_d = s_q;
		s_d.horizontal_gate_p = s_q.horizontal_gate;
		s_d.vref_p = s_q.vref;
		s_d.rdata = 32'h0000_0000;
		s_d.data = IPT_INVALID;
		s_d.qual = 1'b0;
		// Register writes
		if (i_wr) begin
			case (i_addr)
				IPT_REG_CTRL: s_d.ctrl = i_wdata[7:0];
				IPT_REG_DID: s_d.text_header_identifier = i_wdata[5:0];
				IPT_REG_SDID: s_d.sdid = i_wdata[5:0];
				IPT_REG_PINMAP: s_d.pinmap = i_wdata[14:0];
				IPT_REG_POL: s_d.pol = i_wdata[4:0];
				default: ;
			endcase
		end
		// Register reads, data in next cycle
		if (i_rd) begin
			case (i_addr)
				IPT_REG_CTRL: s_d.rdata = {24'h0, s_q.ctrl};
				IPT_REG_DID: s_d.rdata = {26'h0, s_q.text_header_identifier};
				IPT_REG_SDID: s_d.rdata = {26'h0, s_q.sdid};
				IPT_REG_PINMAP: s_d.rdata = {17'h0, s_q.pinmap};
				IPT_REG_POL: s_d.rdata = {27'h0, s_q.pol};
				IPT_REG_STATUS: s_d.rdata = {25'h0, s_q.st};
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end
		// Text collection into the write section
		if (i_txt_valid && o_txt_ready) begin
			s_d.wptr = s_q.wptr + AW'(1);
			if (i_txt.last) begin
				s_d.full[s_q.wsec] = 1'b1;
				s_d.wsec = ~s_q.wsec;
				s_d.wptr = '0;
				if (s_q.wsec) begin
					s_d.len1 = 6'(s_q.wptr + AW'(1));
					s_d.hdr1 = i_txt_hdr;
				end else begin
					s_d.len0 = 6'(s_q.wptr + AW'(1));
					s_d.hdr0 = i_txt_hdr;
				end
			end
		end
		// Output sequencer; held cycles repeat with invalid output
		case (s_q.st)
			ST_IDLE: begin
				s_d.horizontal_gate = 1'b0;
				if (!hold && s_q.full[s_q.rsec] && !i_vid_valid) begin
					s_d.code_txt = 1'b1;
					s_d.cs = 8'h00;
					s_d.field = cur_hdr.field;
					if (sav_mode) begin
						s_d.code = ipt_code(s_q.text_header_identifier == IPT_DID_SAV_HI, cur_hdr.field, 1'b1, 1'b0);
						s_d.code_eav = 1'b0;
						s_d.st = no_codes ? ST_HDR : ST_PRE;
						s_d.sliced = 1'b0;
					end else begin
						s_d.st = ST_PRE;
						s_d.code_eav = 1'b0;
						s_d.code = ipt_par6(s_q.text_header_identifier);
					end
					s_d.pre = 2'd0;
					s_d.hdr_i = 3'd0;
				end else if (!hold && i_vid_valid && i_vid.sol) begin
					s_d.code_txt = 1'b0;
					s_d.code_eav = 1'b0;
					s_d.field = i_vid.field;
					s_d.vref = !i_vid.vblank;
					s_d.code = ipt_code(i_vid.task_b ? ~s_q.ctrl[IPT_CTRL_PAGEB_BIT]
						: ~s_q.ctrl[IPT_CTRL_PAGEA_BIT], i_vid.field, i_vid.vblank, 1'b0);
					s_d.st = no_codes ? ST_VID : ST_PRE;
					s_d.pre = 2'd0;
				end
			end
			ST_PRE: if (!hold) begin
				s_d.horizontal_gate = 1'b0; // Gate ends after the last pixel
				if (!s_q.code_eav && s_q.code_txt && !sav_mode) begin
					s_d.data = (s_q.pre == 2'd0) ? 8'h00 : IPT_PRE_FF;
				end else begin
					s_d.data = (s_q.pre == 2'd0) ? IPT_PRE_FF : 8'h00;
				end
				s_d.qual = 1'b1;
				s_d.pre = s_q.pre + 2'd1;
				if (s_q.pre == 2'd2) begin
					s_d.st = ST_CODE;
				end
			end
			ST_CODE: if (!hold) begin
				s_d.data = s_q.code;
				s_d.qual = 1'b1;
				if (s_q.code_eav) begin
					s_d.st = ST_IDLE;
					if (s_q.code_txt) s_d.rsec = ~s_q.rsec;
				end else if (s_q.code_txt) begin
					s_d.cs = s_q.code;
					s_d.st = ST_HDR;
					if (!sav_mode) s_d.sliced = 1'b1;
				end else begin
					s_d.sliced = 1'b0;
					s_d.st = ST_VID;
				end
			end
			ST_VID: if (!hold) begin
				if (i_vid_valid) begin
					s_d.data = i_vid.data;
					s_d.qual = 1'b1;
					s_d.horizontal_gate = 1'b1; // Gate high from the first pixel byte until the line ends, held and idle gaps included
					if (i_vid.eol) begin
						s_d.code = ipt_code(i_vid.task_b ? ~s_q.ctrl[IPT_CTRL_PAGEB_BIT]
							: ~s_q.ctrl[IPT_CTRL_PAGEA_BIT], s_q.field,
							i_vid.vblank | i_vid.last_active, 1'b1);
						s_d.code_eav = 1'b1;
						s_d.pre = 2'd0;
						s_d.st = no_codes ? ST_IDLE : ST_PRE;
					end
				end
			end
			ST_HDR: if (!hold) begin
				// Header: SDID, DC, IDI1, IDI2
				s_d.qual = 1'b1;
				case (s_q.hdr_i)
					3'd0: s_d.data = ipt_par6(s_q.sdid);
					3'd1: s_d.data = ipt_par6(sav_mode ? IPT_DC_FIXED : anc_dc);
					3'd2: s_d.data = ipt_par7({cur_hdr.field, cur_hdr.line_num[8:3]});
					default: s_d.data = ipt_par7({cur_hdr.line_num[2:0], cur_hdr.std});
				endcase
				s_d.cs = s_q.cs + s_d.data;
				s_d.hdr_i = s_q.hdr_i + 3'd1;
				s_d.cnt = 6'd0;
				if (s_q.hdr_i == 3'd3) s_d.st = ST_TXT;
			end
			ST_TXT: if (!hold) begin
				// Gapless text bytes from the ready section
				s_d.qual = 1'b1;
				if (s_q.cnt < cur_len) begin
					s_d.data = ipt_remap(mem_rdata, s_q.ctrl[IPT_CTRL_REMAP_BIT]);
				end else begin
					s_d.data = IPT_FILL;
				end
				s_d.cs = s_q.cs + s_d.data;
				s_d.cnt = s_q.cnt + 6'd1;
				if ((sav_mode && s_q.cnt == 6'(IPT_DC_BYTES - 3))
						|| (!sav_mode && s_q.cnt == 6'({anc_dc, 2'b00} - 8'd3))) begin
					s_d.st = ST_TAIL;
					s_d.tail_i = 1'b0;
					s_d.full[s_q.rsec] = 1'b0;
				end
			end
			ST_TAIL: if (!hold) begin
				s_d.qual = 1'b1;
				s_d.data = s_q.tail_i ? {1'b0, 1'b0, cur_len} : s_q.cs;
				s_d.tail_i = 1'b1;
				if (s_q.tail_i) begin
					s_d.code = ipt_code(s_q.text_header_identifier == IPT_DID_SAV_HI, s_q.field, 1'b1, 1'b1);
					s_d.code_eav = 1'b1;
					s_d.pre = 2'd0;
					if (sav_mode && !no_codes) begin
						s_d.st = ST_PRE;
					end else begin
						s_d.st = ST_IDLE;
						s_d.rsec = ~s_q.rsec;
					end
				end
			end
			default: s_d.st = ST_IDLE;
		endcase
		// A new line may overwrite only a freed section
		if (s_d.full[s_q.rsec] == 1'b0 && s_q.full[s_q.rsec]) s_d.cnt = s_d.cnt;
	end
	// State register
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.ctrl <= IPT_CTRL_RST;
			s_q.text_header_identifier <= IPT_DID_RST;
			s_q.sdid <= IPT_SDID_RST;
			s_q.pinmap <= IPT_PINMAP_RST;
			s_q.pol <= IPT_POL_RST;
		end else begin
			s_q <= s_d;
		end
	end
endmodule
`default_nettype wire

// *** ipt_port_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
// Watches the image port pins and register port
module ipt_port_chk import ipt_pkg::*; (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic i_output_hold_gate_in,
	input wire logic o_vid_ready,
	input wire logic [7:0] o_data,
	input wire logic o_output_qualifier_pin,
	input wire logic o_horizontal_ref_pin,
	input wire logic o_general_purpose_out_a
);
	logic [5:0] did_q; // Shadow of the identifier
	logic [1:0] cfg_q; // Pin map or polarity moved off default
	logic sav_q; // No identifier below 3E written since reset
	wire logic dflt = (cfg_q == 2'b00); // Pins carry their default events

	// Shadow of the set-up written over the register port
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			did_q <= IPT_DID_RST;
			cfg_q <= 2'b00;
			sav_q <= 1'b1;
		end else if (i_wr) begin
			if (i_addr == IPT_REG_DID) did_q <= i_wdata[5:0];
			if (i_addr == IPT_REG_DID && i_wdata[5:0] < IPT_DID_SAV_HI) sav_q <= 1'b0;
			if (i_addr == IPT_REG_PINMAP) cfg_q[0] <= |i_wdata[14:0];
			if (i_addr == IPT_REG_POL) cfg_q[1] <= |i_wdata[4:0];
		end
	end

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);

	reset_quiet_a: assert property (disable iff (1'b0) !i_rst_n |=> o_data == IPT_INVALID)
		else $error("data bus not 00 after reset");
	pins_reset_a: assert property (disable iff (1'b0)
		!i_rst_n |=> !o_output_qualifier_pin && !o_horizontal_ref_pin)
		else $error("reference pins not idle after reset");
	did_readback_a: assert property (i_rd && i_addr == IPT_REG_DID |=> o_rdata[5:0] == $past(did_q))
		else $error("identifier readback wrong");
	hold_ready_a: assert property (i_output_hold_gate_in |-> !o_vid_ready)
		else $error("video taken while held");
	hold_data_a: assert property (i_output_hold_gate_in |=> o_data == IPT_INVALID)
		else $error("data bus not 00 while held");
	hold_qual_a: assert property (dflt && i_output_hold_gate_in |=> ##1 !o_output_qualifier_pin)
		else $error("qualifier active while held");
	invalid_zero_a: assert property (dflt && !o_output_qualifier_pin |-> $past(o_data) == IPT_INVALID)
		else $error("unqualified byte not 00");
	sliced_sav_a: assert property (dflt && sav_q |-> !o_general_purpose_out_a)
		else $error("sliced flag set in code framing mode");

	hold_seen_c: cover property (i_output_hold_gate_in ##1 !i_output_hold_gate_in);
	qual_rise_c: cover property ($rose(o_output_qualifier_pin));
	sliced_rise_c: cover property ($rose(o_general_purpose_out_a));
endmodule

bind ipt_port ipt_port_chk ipt_port_chk_inst (.i_clk_sys, .i_rst_n, .i_addr, .i_wdata, .i_wr,
	.i_rd, .o_rdata, .i_output_hold_gate_in, .o_vid_ready, .o_data, .o_output_qualifier_pin,
	.o_horizontal_ref_pin, .o_general_purpose_out_a);
`default_nettype wire

// *** ipt_rx_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Receiving frame buffer: keeps only qualified bytes
module ipt_rx_model (
	input wire logic i_clk_sys,
	input wire logic [7:0] i_data,
	input wire logic i_qual,
	input wire logic i_sliced
);
	logic [7:0] data_q; // Byte aligned with the registered pins
	logic [7:0] got[$]; // Captured byte stream
	logic saw_sliced = 1'b0; // A qualified byte came under the sliced flag

	// Capture on qualifier only; 00 filler never moves the write pointer
	always @(posedge i_clk_sys) begin
		data_q <= i_data;
		if (i_qual) got.push_back(data_q);
		if (i_qual && i_sliced) saw_sliced <= 1'b1;
	end
endmodule
`default_nettype wire

// *** ipt_txt_mem.sv ***
`timescale 1ns/10ps
`default_nettype none
// Two-section text line store, registered read data
module ipt_txt_mem import ipt_pkg::*; #(
	parameter int DEPTH = IPT_TXT_DEPTH
) (
	input wire logic i_clk_sys,
	input wire logic i_we,
	input wire logic i_wsec,
	input wire logic [$clog2(DEPTH)-1:0] i_waddr,
	input wire logic [7:0] i_wdata,
	input wire logic i_rsec,
	input wire logic [$clog2(DEPTH)-1:0] i_raddr,
	output logic [7:0] o_rdata
);
	// Storage for both sections
	logic [7:0] mem [2*DEPTH];
	// Write port and registered read port
	always_ff @(posedge i_clk_sys) begin
		if (i_we) begin
			mem[{i_wsec, i_waddr}] <= i_wdata;
		end
		o_rdata <= mem[{i_rsec, i_raddr}];
	end
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the image port output stage
module tb_top import ipt_pkg::*;;
	logic clk, rst_n, wr, rd, vid_valid, txt_valid, hold; // Bench-driven controls
	logic [3:0] addr; // Register index
	logic [31:0] wdata, rdata; // Register data
	ipt_vid_t vid; // Video beat
	ipt_txt_t txt; // Text byte
	ipt_hdr_t hdr; // Text line header
	logic vid_ready, txt_ready, qual, horizontal_gate, vref, gpa, gpb; // Design handshakes and pins
	logic [7:0] data; // Output byte bus
	int n_fail, tests_run; // Verdict counters
	int n_horizontal_gate; // Cycles seen with the horizontal pin high
	logic [7:0] exp_q[$]; // Expected qualified stream
	// Line table: ctrl, flags {field, vblank, last, task b}, start code, end code
	logic [31:0] rows[8] = '{32'h0000809D, 32'h080A497F, 32'h08042538, 32'h000CECF1,
		32'h000280B6, 32'h02000000, 32'h10010E13, 32'h0400809D};

	ipt_port ipt_port_inst (.i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_vid_valid(vid_valid), .i_vid(vid),
		.o_vid_ready(vid_ready), .i_txt_valid(txt_valid), .i_txt(txt), .i_txt_hdr(hdr),
		.o_txt_ready(txt_ready), .i_output_hold_gate_in(hold), .o_data(data),
		.o_output_qualifier_pin(qual), .o_horizontal_ref_pin(horizontal_gate), .o_vertical_ref_pin(vref),
		.o_general_purpose_out_a(gpa), .o_general_purpose_out_b(gpb));
	ipt_rx_model ipt_rx_model_inst (.i_clk_sys(clk), .i_data(data), .i_qual(qual), .i_sliced(gpa));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Counts cycles with the horizontal reference pin high
	always @(posedge clk) begin
		if (horizontal_gate === 1'b1) n_horizontal_gate++;
	end

	// Compare one result, count and report
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	// Register write, one strobe cycle
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask

	// Register read, data taken in the following cycle
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask

	// One video line of six pixels, advancing on the ready handshake
	task automatic send_line(input logic f, input logic vb, input logic la, input logic tb);
		int i;
		i = 0;
		while (i < 6) begin
			vid_valid <= 1'b1;
			vid <= '{8'h40 + 8'(i), i == 0, i == 5, vb, la, f, tb};
			@(posedge clk);
			if (vid_ready) i++;
		end
		vid_valid <= 1'b0;
	endtask

	// One four-byte text line, last byte closes the section
	task automatic send_txt(input logic [31:0] b);
		int i;
		i = 0;
		while (i < 4) begin
			txt_valid <= 1'b1;
			txt <= '{b[31 - 8 * i -: 8], i == 3};
			hdr <= '{9'h015, 4'h1, 1'b0};
			@(posedge clk);
			if (txt_ready) i++;
		end
		txt_valid <= 1'b0;
		@(posedge clk);
	endtask

	// True when the captured stream holds four bytes in a row
	function automatic logic has(input logic [31:0] p);
		logic [7:0] g[$];
		g = ipt_rx_model_inst.got;
		has = 1'b0;
		for (int i = 0; i + 3 < g.size(); i++) begin
			if ({g[i], g[i + 1], g[i + 2], g[i + 3]} === p) has = 1'b1;
		end
	endfunction

	// Wait for the expected stream, then compare it byte by byte
	task automatic cmp_stream();
		for (int k = 0; k < 200 && ipt_rx_model_inst.got.size() < exp_q.size(); k++) @(posedge clk);
		repeat (4) @(posedge clk);
		chk("count", exp_q.size(), ipt_rx_model_inst.got.size());
		foreach (exp_q[m]) begin
			if (m < ipt_rx_model_inst.got.size()) chk("byte", exp_q[m], ipt_rx_model_inst.got[m]);
		end
	endtask

	// Prints counts and verdict, ends the run
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		#50us;
		n_fail++;
		$display("mismatch watchdog expected end seen hang");
		conclude();
	end

	// Main sequence
	initial begin
		logic [31:0] r;
		int h; // Pin count before a line
		{rst_n, wr, rd, vid_valid, txt_valid, hold} = 6'h00;
		{addr, wdata, vid, txt, hdr} = '0;
		n_fail = 0;
		tests_run = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// Reset values, and an unmapped index reading zero
		for (int i = 0; i < 6; i++) begin
			rd_reg(i == 5 ? 4'hF : 4'(i), r);
			chk("reg", i == 1 ? 32'h3E : 32'h0, r);
		end
		// Inverted qualifier idles high
		wr_reg(IPT_REG_POL, 32'h1);
		repeat (3) @(posedge clk);
		chk("qual_pol", 32'h1, qual);
		wr_reg(IPT_REG_POL, 32'h0);
		// Video lines with every code kind, page select and suppression
		foreach (rows[j]) begin
			wr_reg(IPT_REG_CTRL, {24'h0, rows[j][31:24]});
			ipt_rx_model_inst.got.delete();
			exp_q.delete();
			h = n_horizontal_gate;
			if (!rows[j][25]) exp_q = {8'hFF, 8'h00, 8'h00, rows[j][15:8]};
			for (int k = 0; k < 6; k++) exp_q.push_back(8'h40 + 8'(k));
			if (!rows[j][25]) exp_q = {exp_q, 8'hFF, 8'h00, 8'h00, rows[j][7:0]};
			if (j == 0) fork
				begin
					repeat (5) @(posedge clk);
					hold <= 1'b1;
					repeat (4) @(posedge clk);
					hold <= 1'b0;
				end
			join_none
			send_line(rows[j][19], rows[j][18], rows[j][17], rows[j][16]);
			cmp_stream();
			chk("horizontal_gate_len", rows[j][26] ? 32'd1 : 32'd6, n_horizontal_gate - h);
			chk("vref", {31'h0, !rows[j][26] && !rows[j][18]}, vref);
			chk("field", {31'h0, rows[j][19]}, gpb);
		end
		// Ancillary framed text with value remapping
		wr_reg(IPT_REG_DID, 32'h10);
		wr_reg(IPT_REG_CTRL, 32'h1);
		ipt_rx_model_inst.got.delete();
		send_txt(32'h00FF5521);
		for (int k = 0; k < 300 && !has(32'h03FC5521); k++) @(posedge clk);
		chk("remap", 32'h1, has(32'h03FC5521));
		chk("anc_head", 32'h1, has(32'h00FFFF50));
		chk("sliced_flag", 32'h1, ipt_rx_model_inst.saw_sliced);
		// Two lines back to back, values passed unchanged
		wr_reg(IPT_REG_CTRL, 32'h0);
		ipt_rx_model_inst.got.delete();
		send_txt(32'h00FF5521);
		send_txt(32'h00FF5521);
		for (int k = 0; k < 400 && !has(32'h00FF5521); k++) @(posedge clk);
		chk("no_remap", 32'h1, has(32'h00FF5521));
		conclude();
	end
endmodule
`default_nettype wire
